// ---- rxseq_pkg.sv ----
/*
 * Shared constants and types of the receiver restart and mode sequencer:
 * register offsets, field positions, chip mode codes and timing counts.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package rxseq_pkg;

    // Register byte offsets
    localparam logic [3:0] REG_CMD     = 4'h0;  // Write-only command strobes
    localparam logic [3:0] REG_SEQ_CFG = 4'h4;  // Sequencer setup register
    localparam logic [3:0] REG_RX_CFG  = 4'h8;  // Receiver setup register
    localparam logic [3:0] REG_STATUS  = 4'hC;  // Read-only status

    // Command bits
    localparam int CMD_LAUNCH  = 0;
    localparam int CMD_STOP    = 1;
    localparam int CMD_RESTART = 2;
    localparam int CMD_RELOCK  = 3;

    // Sequencer setup fields
    localparam int SEQ_OPMODE_LSB = 0;  // Three bits of manual chip mode
    localparam int SEQ_IDLE_PWR   = 3;
    localparam int SEQ_LAUNCH_LSB = 4;  // Two bits
    localparam int SEQ_LOWPWR     = 6;
    localparam int SEQ_IDLE_EXIT  = 7;

    // Receiver setup fields
    localparam int RX_AUTO_LSB  = 0;    // Two bits
    localparam int RX_COLL_EN   = 2;
    localparam int RX_LEVEL_LSB = 8;    // Eight bits, one dB a step
    localparam int RX_DELAY_LSB = 16;   // Eight bits, one microsecond a step

    // Reset values
    localparam logic [31:0] SEQ_CFG_RST = 32'h0000_0001;
    localparam logic [31:0] RX_CFG_RST  = 32'h0000_0000;

    // Chip mode codes
    localparam logic [2:0] MODE_SLEEP   = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_TX      = 3'h3;
    localparam logic [2:0] MODE_RX      = 3'h5;

    // Field encodings
    localparam logic [1:0] AUTO_OFF    = 2'h0;
    localparam logic [1:0] AUTO_SAME   = 2'h1;
    localparam logic [1:0] AUTO_RELOCK = 2'h2;
    localparam logic [1:0] GO_LOWPWR   = 2'h0;
    localparam logic [1:0] GO_RX       = 2'h1;
    localparam logic [1:0] GO_TX       = 2'h2;

    // Timing
    localparam int CLK_MHZ       = 50;
    localparam int DELAY_UNIT_US = 1;
    localparam int RELOCK_US     = 10;
    localparam logic [15:0] UNIT_CYC   = 16'(CLK_MHZ * DELAY_UNIT_US);
    localparam logic [15:0] RELOCK_CYC = 16'(CLK_MHZ * RELOCK_US);

    // Sequencer states
    typedef enum logic [2:0] {
        SQ_OFF, SQ_IDLE, SQ_TX, SQ_RX, SQ_PKTRX, SQ_LOWPWR, SQ_RXTO
    } rxseq_state_t;

    // Events from the radio datapath
    typedef struct packed {
        logic payloadDone;    // payload_complete_event
        logic fifoEmpty;
        logic fifoLevel;      // fifo_level_event
        logic firstTimer;     // first_timer_event
        logic txDone;
        logic signalExpired;  // signal_wait_expired
        logic preambleExpired;
        logic syncExpired;
        logic modeSettled;    // mode_settled_flag
    } rxseq_evt_t;

endpackage : rxseq_pkg

// ---- rxseq_core.sv ----
/*
 * Receiver restart control and top level mode sequencer, with a classic
 * Wishbone register slave. Radio events and the signal strength come from
 * datapath logic on the same clock, so they are read without synchronisers.
 */
// How it works
// RQ1: Select 00: no automatic restart after packets
// RQ2: Select 01: restart after FIFO empty plus delay
// RQ3: Select 10: extra relock delay before restart
// RQ4: Sudden signal rise during receive restarts receiver
// RQ5: Collision restart only while enable bit set
// RQ6: Collision threshold programmable in one dB steps
// RQ7: Launch from Sleep/Standby; that mode becomes initial
// RQ8: Stop forces sequencer off from any state
// RQ9: Host never writes launch and stop together
// RQ10: Seven sequencer states, four main, three transitory; the code holds packet-received until stop, so only two last one cycle
// RQ11: Off from low-power selection restores initial mode
// RQ12: Idle holds chosen low power, waits first timer
// RQ13: Idle power 0 Standby, 1 Sleep
// RQ14: Launch field picks low-power, receive, transmit, fifo-transmit
// RQ15: Low-power target 0 off, 1 idle
// RQ16: Initial mode latched at launch
// RQ17: Packet-received keeps receiver on, packet in FIFO
// RQ18: Any wait expiry drives receive-timeout state
// RQ19: Manual restart ignored unless mode settled
// RQ20: Idle exit 0 transmit, 1 receive on timer
// RQ21: Launch and stop sampled on clock; stop wins
// RQ22: Restarts only in receive, never while delaying
`timescale 1ns/1ns
module rxseq_core
    import rxseq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Radio datapath
    input  wire rxseq_evt_t  evt,
    input  wire logic [7:0]  rssi,
    // Radio control
    output logic      [2:0]  chipMode,
    output logic             rxRestart,
    output logic             rxRelock
);

    // Everything the block remembers lives in this one struct, so the
    // next-state process copies it whole and edits only what moves
    // Whole module state
    typedef struct packed {
        logic         ack;
        logic [31:0]  rdat;
        logic [31:0]  seqCfg;     // Sequencer setup register
        logic [31:0]  rxCfg;      // Receiver setup register
        rxseq_state_t seq;
        logic [2:0]   initMode;   // Mode at launch
        logic         waitFifo;   // Launch held for FIFO level
        logic [2:0]   mode;
        logic         restart;
        logic         relock;
        logic         armed;      // Packet seen, waiting for FIFO empty
        logic         relockDue;  // Pending restart needs relock
        logic [15:0]  delayCnt;
        logic [7:0]   rssiRef;    // Quietest level since restart
    } rxseq_st_t;

    rxseq_st_t st;       // Current state
    rxseq_st_t next_st;  // Next state

    // Combinational helpers; none of them is stored
    // Decoded bus and command signals, receiver status, collision, timeout and delay load
    logic        req;
    logic        wrNow;
    logic [31:0] laneMask;
    logic        cmdLaunch;
    logic        cmdStop;
    logic        cmdRestart;
    logic        cmdRelock;
    logic        inRx;
    logic        busy;
    logic        collide;
    logic        anyExpired;
    logic [15:0] loadCnt;

    // Byte lane mask from the select lines
    // Lanes with a low select keep their old byte on a write
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gLane
            assign laneMask[g*8 +: 8] = {8{sel_i[g]}};
        end
    endgenerate

    // Ack comes one cycle after the request is seen; the write waits for
    // ack so that it lands exactly once, at the edge the master samples
    // Writes land on the edge that samples ack, as the master expects
    assign req   = cyc_i & stb_i;
    assign wrNow = req & we_i & st.ack;

    // Command strobes; launch and stop are seen on this clock only
    // Each strobe lives for a single ack edge; a request held longer
    // acks again every second cycle and applies the command again
    assign cmdStop    = wrNow & (adr_i == REG_CMD) & sel_i[0]
                        & dat_i[CMD_STOP];
    assign cmdLaunch  = wrNow & (adr_i == REG_CMD) & sel_i[0]
                        & dat_i[CMD_LAUNCH] & ~cmdStop;      // [RQ21]
    assign cmdRestart = wrNow & (adr_i == REG_CMD) & sel_i[0]
                        & dat_i[CMD_RESTART];
    assign cmdRelock  = wrNow & (adr_i == REG_CMD) & sel_i[0]
                        & dat_i[CMD_RELOCK];

    // Receiver activity and restart hold-off
    // Busy covers both the armed wait for an empty FIFO and the running
    // delay; manual and collision restarts are held off while it is high
    assign inRx = (st.mode == MODE_RX);
    assign busy = (st.delayCnt != 16'h0000) | st.armed;

    // Collision: rise above the quiet level by the programmed dB steps
    // The sum is one bit wider so a high level cannot wrap round and
    // turn a quiet channel into a false collision
    assign collide = st.rxCfg[RX_COLL_EN] & inRx & ~busy & ~st.restart
        & ({1'b0, rssi} > ({1'b0, st.rssiRef}
        + {1'b0, st.rxCfg[RX_LEVEL_LSB +: 8]}));          // [RQ4] [RQ5] [RQ6]

    // Any of the three wait timeouts
    // They are treated alike; which one fired is not kept
    assign anyExpired = evt.signalExpired | evt.preambleExpired
                        | evt.syncExpired;                  // [RQ18]

    // Post-packet delay in cycles, longer when the synthesizer must relock
    // One extra cycle so a zero delay still pulses a cycle after the
    // FIFO empties; the widest load, with the relock time added, still
    // fits the sixteen-bit counter
    always_comb begin
        loadCnt = 16'(st.rxCfg[RX_DELAY_LSB +: 8] * UNIT_CYC) + 16'h0001;
        if (st.rxCfg[RX_AUTO_LSB +: 2] == AUTO_RELOCK) begin
            loadCnt = loadCnt + RELOCK_CYC;                 // [RQ3]
        end
    end

    // Next state of the whole block
    // Pulses default low each cycle; every other field holds unless a
    // branch below changes it
    always_comb begin
        next_st         = st;
        next_st.restart = 1'b0;
        next_st.relock  = 1'b0;

        // Bus slave: one wait state, then ack for one cycle
        // Read data is zero whenever ack is low, keeping the bus quiet
        next_st.ack  = req & ~st.ack;
        next_st.rdat = 32'h0000_0000;
        if (req & ~st.ack & ~we_i) begin
            unique case (adr_i)
                REG_SEQ_CFG: next_st.rdat = st.seqCfg;
                REG_RX_CFG:  next_st.rdat = st.rxCfg;
                REG_STATUS:  next_st.rdat = {23'h0, st.armed, busy,
                                evt.modeSettled, st.mode, st.seq};
                default:     next_st.rdat = 32'h0000_0000;  // Unmapped
            endcase
        end

        // Register writes, lane by lane
        // Unused bits are masked so they always read back as zero
        // Writes to the command and status offsets change no register
        if (wrNow && adr_i == REG_SEQ_CFG) begin
            next_st.seqCfg = ((st.seqCfg & ~laneMask) | (dat_i & laneMask))
                             & 32'h0000_00FF;
        end
        if (wrNow && adr_i == REG_RX_CFG) begin
            next_st.rxCfg = ((st.rxCfg & ~laneMask) | (dat_i & laneMask))
                            & 32'h00FF_FF07;
        end

        // Sequencer; receive-timeout and low-power selection last one cycle, packet-received holds
        // Transitory states need no counter of their own
        // A launch counts only from off and only in Sleep or Standby;
        // any other manual mode leaves the sequencer where it is
        unique case (st.seq)
            SQ_OFF: begin
                if (cmdLaunch && (st.seqCfg[2:0] == MODE_SLEEP
                    || st.seqCfg[2:0] == MODE_STANDBY)) begin   // [RQ7]
                    next_st.initMode = st.seqCfg[2:0];          // [RQ16]
                    unique case (st.seqCfg[SEQ_LAUNCH_LSB +: 2]) // [RQ14]
                        GO_LOWPWR: next_st.seq = SQ_LOWPWR;
                        GO_RX:     next_st.seq = SQ_RX;
                        GO_TX:     next_st.seq = SQ_TX;
                        default: begin
                            next_st.seq      = SQ_TX;
                            next_st.waitFifo = 1'b1;
                        end
                    endcase
                end
            end
            SQ_IDLE: begin
                // Only the first timer event moves idle on
                // A timeout or a packet seen here is ignored
                if (evt.firstTimer) begin                       // [RQ12]
                    next_st.seq = st.seqCfg[SEQ_IDLE_EXIT]
                                  ? SQ_RX : SQ_TX;              // [RQ20]
                end
            end
            SQ_TX: begin
                // With a FIFO-level launch the transmitter waits for the
                // level event; the chip keeps its initial mode meanwhile
                if (st.waitFifo) begin
                    if (evt.fifoLevel) begin
                        next_st.waitFifo = 1'b0;
                    end
                end else if (evt.txDone) begin
                    next_st.seq = SQ_LOWPWR;
                end
            end
            SQ_RX: begin
                // A timeout outranks a packet finishing in the same cycle
                if (anyExpired) begin
                    next_st.seq = SQ_RXTO;                      // [RQ18]
                end else if (evt.payloadDone) begin
                    next_st.seq = SQ_PKTRX;
                end
            end
            SQ_PKTRX: begin
                // Receiver stays on; packet waits in the FIFO     [RQ17]
                // Leaving is outside this block; only stop ends it
                next_st.seq = SQ_PKTRX;
            end
            SQ_RXTO: begin
                // Transitory: one cycle, then low-power selection
                next_st.seq = SQ_LOWPWR;
            end
            SQ_LOWPWR: begin
                // Transitory: one cycle, picks idle or off
                if (st.seqCfg[SEQ_LOWPWR]) begin
                    next_st.seq = SQ_IDLE;                      // [RQ15]
                end else begin
                    next_st.seq = SQ_OFF;                       // [RQ15]
                    next_st.seqCfg[SEQ_OPMODE_LSB +: 3] =
                        st.initMode;                            // [RQ11]
                end
            end
        endcase

        // Stop overrides every state, including a launch      [RQ8] [RQ21]
        // It stands after the state case so that it beats any transition
        // decided in the same cycle
        if (cmdStop) begin
            next_st.seq      = SQ_OFF;
            next_st.waitFifo = 1'b0;
        end

        // Chip mode follows the sequencer state                  [RQ10]
        // Worked out from the next state so mode and state change on one
        // edge; transitory states keep the mode they found
        unique case (next_st.seq)
            SQ_OFF:   next_st.mode = next_st.seqCfg[2:0];
            SQ_IDLE:  next_st.mode = st.seqCfg[SEQ_IDLE_PWR]
                                     ? MODE_SLEEP : MODE_STANDBY; // [RQ13]
            SQ_TX:    next_st.mode = next_st.waitFifo
                                     ? st.initMode : MODE_TX;
            SQ_RX:    next_st.mode = MODE_RX;
            SQ_PKTRX: next_st.mode = MODE_RX;                     // [RQ17]
            default:  next_st.mode = st.mode;
        endcase

        // Automatic restart after a valid packet
        // Leaving receive drops any pending restart; otherwise it would
        // fire on the next visit to receive with a stale delay
        if (!inRx) begin
            next_st.armed    = 1'b0;                             // [RQ22]
            next_st.delayCnt = 16'h0000;
        end else if (st.delayCnt != 16'h0000) begin
            next_st.delayCnt = st.delayCnt - 16'h0001;
            if (st.delayCnt == 16'h0001) begin
                next_st.restart = ~st.relockDue;                 // [RQ2]
                next_st.relock  = st.relockDue;                  // [RQ3]
            end
        end else if (st.armed) begin
            if (evt.fifoEmpty) begin
                next_st.armed     = 1'b0;
                next_st.delayCnt  = loadCnt;                     // [RQ2]
                next_st.relockDue = (st.rxCfg[RX_AUTO_LSB +: 2]
                                     == AUTO_RELOCK);
            end
        end else if (evt.payloadDone
                     && st.rxCfg[RX_AUTO_LSB +: 2] != AUTO_OFF) begin
            next_st.armed = 1'b1;                                // [RQ1]
        end

        // Manual restart only once the mode has settled   [RQ19] [RQ22]
        // The settled flag is judged at the edge that takes the write;
        // relock wins over a plain restart, as it covers both cases
        if (inRx && !busy && evt.modeSettled) begin
            if (cmdRelock) begin
                next_st.relock = 1'b1;
            end else if (cmdRestart) begin
                next_st.restart = 1'b1;
            end
        end

        // Collision restart keeps the current frequency
        // No relock here: a collision does not move the carrier
        if (collide) begin
            next_st.restart = 1'b1;                              // [RQ4]
        end

        // Quiet level restarts at each restart, then tracks the minimum
        // Tracking the minimum keeps slow fading from reading as a collision
        if (next_st.restart || next_st.relock || !inRx) begin
            next_st.rssiRef = rssi;
        end else if (rssi < st.rssiRef) begin
            next_st.rssiRef = rssi;
        end
    end

    // State register
    // Reset gives Standby with the sequencer off and no pulse pending
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st           <= '0;
            st.seqCfg    <= SEQ_CFG_RST;
            st.rxCfg     <= RX_CFG_RST;
            st.seq       <= SQ_OFF;
            st.initMode  <= MODE_STANDBY;
            st.mode      <= MODE_STANDBY;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    // Every output is a register field with no logic after it
    assign dat_o     = st.rdat;
    assign ack_o     = st.ack;
    assign chipMode  = st.mode;
    assign rxRestart = st.restart;
    assign rxRelock  = st.relock;

endmodule : rxseq_core

// ---- rxseq_monitor.sv ----
/* Checker for the restart and mode sequencer core.
   Sees only the core's ports; bound to every core instance below. */
`timescale 1ns/1ns
module rxseq_monitor
    import rxseq_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Radio side
    input wire rxseq_evt_t  evt,
    input wire logic [7:0]  rssi,
    input wire logic [2:0]  chipMode,
    input wire logic        rxRestart,
    input wire logic        rxRelock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_ack_next:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single:
        assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_data_idle:
        assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    chk_cmd_read:
        assert property (ack_o && !we_i && (adr_i == REG_CMD
            || adr_i[1:0] != 2'h0) |-> dat_o == 32'h0)
        else $error("command or unmapped read not zero");
    chk_restart_rx:
        assert property (rxRestart |-> $past(chipMode) == MODE_RX)
        else $error("restart outside receive");
    chk_relock_rx:
        assert property (rxRelock |-> $past(chipMode) == MODE_RX)
        else $error("relock outside receive");
    chk_relock_pulse:
        assert property (rxRelock |=> !rxRelock)
        else $error("relock pulse too long");
    // Settled flag is judged at the edge that takes the write
    chk_unsettled_ignored:
        assert property (ack_o && we_i && adr_i == REG_CMD && sel_i[0]
            && dat_i[CMD_RESTART] && !evt.modeSettled |=> !rxRestart [*2])
        else $error("restart taken while mode unsettled");
endmodule : rxseq_monitor

bind rxseq_core rxseq_monitor mon (.clk, .rstn, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .evt, .rssi, .chipMode,
    .rxRestart, .rxRelock);

// ---- rxseq_radio_model.sv ----
/* Radio datapath model: passes bench events and signal strength on, and
   raises the settled flag once the chip mode has stood still. */
`timescale 1ns/1ns
module rxseq_radio_model
    import rxseq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bench side
    input  wire rxseq_evt_t evtIn,
    input  wire logic       settleEn,
    input  wire logic [7:0] rssiIn,
    // Core side
    input  wire logic [2:0] chipMode,
    output rxseq_evt_t      evt,
    output logic      [7:0] rssi
);
    logic [2:0] lastMode;  // Mode seen last cycle
    logic [1:0] calm;      // Cycles the mode has held
    // A mode change restarts the settling count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lastMode <= MODE_STANDBY;
            calm     <= 2'h0;
        end else begin
            lastMode <= chipMode;
            if (chipMode != lastMode)
                calm <= 2'h0;
            else if (calm != 2'h3)
                calm <= calm + 2'h1;
        end
    end
    // Bench may withhold settling to test refusal
    always_comb begin
        evt             = evtIn;
        evt.modeSettled = settleEn && (calm == 2'h3);
    end
    assign rssi = rssiIn;
endmodule : rxseq_radio_model

// ---- rxseq_core_tb_top.sv ----
/* Bench for the sequencer core: Wishbone access task, radio events via
   the datapath model, checked call sequences. Needs rxseq_pkg. */
`timescale 1ns/1ns
`define CHK(a, b) begin \
    totalChecks++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("ERROR %0t value %0h", $time, (a)); \
    end \
end
module rxseq_core_tb_top
    import rxseq_pkg::*;
;
    localparam int E_PAY = 8;  // Event bit positions
    localparam int E_EMPTY = 7;
    localparam int E_LEVEL = 6;
    localparam int E_T1 = 5;
    localparam int E_TXD = 4;
    localparam int E_SIG = 3;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] datI = 32'h0;
    logic [31:0] datO;
    logic        ack;
    rxseq_evt_t  evtP = '0;
    rxseq_evt_t  evt;
    logic        settleEn = 1'b1;
    logic [7:0]  rssiIn = 8'h0A;
    logic [7:0]  rssi;
    logic [2:0]  chipMode;
    logic        rxRestart;
    logic        rxRelock;
    logic [31:0] r;
    logic [2:0]  m;
    int          failures = 0;
    int          totalChecks = 0;
    int          rsN, rlN, at;

    always #10 clk = ~clk;

    rxseq_core DUT (.clk, .rstn, .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
        .evt, .rssi, .chipMode, .rxRestart, .rxRelock);
    rxseq_radio_model radio (.clk, .rstn, .evtIn(evtP), .settleEn,
        .rssiIn, .chipMode, .evt, .rssi);

    task complete_run;
        if (failures == 0 && totalChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // One classic cycle; request held up to the edge that samples ack
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datI <= d;
        sel  <= 4'hF;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            failures++;
            $display("ERROR %0t ack timeout", $time);
            complete_run();
        end
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : acc

    // One-cycle radio event
    task ev(input int k);
        evtP <= rxseq_evt_t'(9'h001 << k);
        @(posedge clk);
        evtP <= '0;
        @(posedge clk);
    endtask : ev

    // Sequencer state and chip mode, after transitory states pass
    task st(input logic [2:0] s, input logic [2:0] md);
        repeat (3) @(posedge clk);
        acc(1'b0, REG_STATUS, 32'h0, r);
        `CHK(r[2:0], s)
        `CHK(r[5:3], md)
        `CHK(chipMode, md)
    endtask : st

    // Count restart pulses over a fixed window
    task watch(input int n);
        rsN = 0;
        rlN = 0;
        at = -1;
        for (int j = 0; j < n; j++) begin
            @(negedge clk);
            if (at < 0 && (rxRestart === 1'b1 || rxRelock === 1'b1))
                at = j;
            if (rxRestart === 1'b1)
                rsN++;
            if (rxRelock === 1'b1)
                rlN++;
        end
        @(posedge clk);
    endtask : watch

    task cmd_watch(input logic [31:0] c);
        fork
            acc(1'b1, REG_CMD, c, r);
            watch(8);
        join
    endtask : cmd_watch

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        acc(1'b0, REG_SEQ_CFG, 32'h0, r);
        `CHK(r, SEQ_CFG_RST)
        acc(1'b0, REG_RX_CFG, 32'h0, r);
        `CHK(r, RX_CFG_RST)
        acc(1'b0, 4'h2, 32'h0, r);
        `CHK(r, 32'h0)
        // Every launch choice, alternating between Standby and Sleep
        for (int i = 0; i < 4; i++) begin
            m = i[0] ? MODE_SLEEP : MODE_STANDBY;
            acc(1'b1, REG_SEQ_CFG, 32'(i << 4) | 32'(m), r);
            acc(1'b1, REG_CMD, 32'h1, r);
            if (i == 3) begin
                st(3'h2, m);
                ev(E_LEVEL);
            end
            st(i == 0 ? 3'h0 : (i == 1 ? 3'h3 : 3'h2), i == 0 ? m :
               (i == 1 ? MODE_RX : MODE_TX));
            acc(1'b1, REG_CMD, 32'h2, r);
            st(3'h0, m);
        end
        acc(1'b1, REG_CMD, 32'h3, r);
        st(3'h0, MODE_SLEEP);
        // Idle loop through receive timeouts
        acc(1'b1, REG_SEQ_CFG, 32'h0000_00C9, r);
        acc(1'b1, REG_CMD, 32'h1, r);
        st(3'h1, MODE_SLEEP);
        ev(E_SIG);
        ev(E_PAY);
        st(3'h1, MODE_SLEEP);
        for (int k = 0; k < 3; k++) begin
            ev(E_T1);
            st(3'h3, MODE_RX);
            ev(E_SIG - k);
            st(3'h1, MODE_SLEEP);
        end
        acc(1'b1, REG_SEQ_CFG, 32'h0000_0041, r);
        ev(E_T1);
        st(3'h2, MODE_TX);
        ev(E_TXD);
        st(3'h1, MODE_STANDBY);
        acc(1'b1, REG_CMD, 32'h2, r);
        // Automatic restart, one microsecond delay
        acc(1'b1, REG_RX_CFG, 32'h0001_0001, r);
        acc(1'b1, REG_SEQ_CFG, 32'h0000_0011, r);
        acc(1'b1, REG_CMD, 32'h1, r);
        ev(E_PAY);
        st(3'h4, MODE_RX);
        ev(E_EMPTY);
        watch(60);
        `CHK(rsN, 1)
        `CHK(at >= 48 && at <= 53, 1'b1)
        acc(1'b1, REG_RX_CFG, 32'h0001_0002, r);
        ev(E_PAY);
        ev(E_EMPTY);
        watch(600);
        `CHK(rlN, 1)
        `CHK(at >= 548 && at <= 553, 1'b1)
        acc(1'b1, REG_RX_CFG, 32'h0001_0000, r);
        ev(E_PAY);
        ev(E_EMPTY);
        watch(80);
        `CHK(rsN + rlN, 0)
        // Manual restarts, settled and not
        cmd_watch(32'h4);
        `CHK(rsN, 1)
        cmd_watch(32'hC);
        `CHK(rlN * 2 + rsN, 2)
        settleEn <= 1'b0;
        cmd_watch(32'h4);
        `CHK(rsN, 0)
        settleEn <= 1'b1;
        acc(1'b1, REG_CMD, 32'h2, r);
        cmd_watch(32'hC);
        `CHK(rsN + rlN, 0)
        // Collision at a five dB threshold
        acc(1'b1, REG_RX_CFG, 32'h0000_0500, r);
        acc(1'b1, REG_CMD, 32'h1, r);
        rssiIn <= 8'h10;
        watch(6);
        `CHK(rsN, 0)
        rssiIn <= 8'h0A;
        acc(1'b1, REG_RX_CFG, 32'h0000_0504, r);
        rssiIn <= 8'h0F;
        watch(6);
        `CHK(rsN, 0)
        rssiIn <= 8'h10;
        watch(6);
        `CHK(rsN, 1)
        complete_run();
    end
endmodule : rxseq_core_tb_top
